// ### rtl/power_rail_control_regs.sv
// Purpose: register bank driving regulator, reference and discharge controls
// Assumes: 50 MHz core_clk, Avalon-MM slave with waitrequest, analog flags asynchronous
// Notes:   every analog control output is a flip-flop; status is synchronised first
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`include "power_rail_control_regs.svh"

module power_rail_control_regs
  import power_rail_control_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // power state from the sequencer
  input wire logic pmu_in_sleep,
  // analog flags, asynchronous
  input wire logic adc_regulator_ready,
  input wire logic flash_supply_above_threshold,
  input wire logic buck_supply_above_threshold,
  input wire logic io_supply_above_threshold,
  input wire logic core_supply_above_threshold,
  input wire logic io_regulator_ready,
  input wire logic low_regulator_ready,
  input wire logic core_regulator_ready,
  input wire logic bandgap_ready,
  // analog controls
  output logic core_rail_discharge,
  output logic buck_rail_discharge,
  output logic io_rail_discharge,
  output logic core_retention_refbuf_en,
  output logic io_retention_refbuf_en,
  output logic reference_hold_force,
  output logic buck_on_in_sleep,
  output logic core_retention_reg_en,
  output logic low_reg_en,
  output logic low_reg_high_drive,
  output logic io_reg_bypass,
  output logic io_retention_reg_en,
  output logic core_reg_en,
  output logic io_reg_en
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // returns 0 dis, 1 status, 2 power control, 3 buck control, 4 unmapped
  function automatic logic [2:0] decode(input logic [31:0] addr);
    if (addr == `RAIL_DISCHARGE_CONTROL_OFS) begin
      decode = 3'h0;
    end else if (addr == `ANALOG_READY_STATUS_OFS) begin
      decode = 3'h1;
    end else if (addr == `REGULATOR_ENABLE_CONTROL_OFS) begin
      decode = 3'h2;
    end else if (addr == `BUCK_CONVERTER_CONTROL_OFS) begin
      decode = 3'h3;
    end else begin
      decode = 3'h4;
    end
  endfunction

  // ----------------------------------------------------------------
  // status synchronisers
  // ----------------------------------------------------------------
  logic [`STS_WIDTH-1:0] sts_raw;
  logic [`STS_WIDTH-1:0] sts_meta_ff;
  logic [`STS_WIDTH-1:0] sts_ff;
  logic sleep_meta_ff;
  logic sleep_ff;

  assign sts_raw = {adc_regulator_ready, flash_supply_above_threshold,
                    buck_supply_above_threshold, io_supply_above_threshold,
                    core_supply_above_threshold, io_regulator_ready,
                    low_regulator_ready, core_regulator_ready, bandgap_ready};

  // flash comparator passes unfiltered; glitches are left to software
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sts_meta_ff <= 9'h000;
      sts_ff <= 9'h000;
      sleep_meta_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      sts_meta_ff <= sts_raw;
      sts_ff <= sts_meta_ff;
      sleep_meta_ff <= pmu_in_sleep;
      sleep_ff <= sleep_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // bus slave and registers
  // ----------------------------------------------------------------
  bus_state_t state_ff, nxt_state;
  logic [2:0] dis_ff, nxt_dis;
  logic [`PC_WIDTH-1:0] pc_ff, nxt_pc;
  logic buck_main_enable_ff, nxt_buck_main_enable;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] resp_ff, nxt_resp;
  logic [2:0] sel;
  logic [31:0] wmask;

  assign sel = decode(avs_address);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // one wait cycle: request taken in idle, answered the next cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_dis = dis_ff;
    nxt_pc = pc_ff;
    nxt_buck_main_enable = buck_main_enable_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    case (state_ff)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = BUS_ANSWER;
          nxt_resp = (sel == 3'h4) ? 2'h2 : 2'h0;
          nxt_rdata = 32'h00000000;
          if (avs_write) begin
            if (sel == 3'h0) begin
              nxt_dis = (dis_ff & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
            end else if (sel == 3'h2) begin
              // bit 15 is never stored, so it can drive nothing
              nxt_pc = (pc_ff & ~wmask[14:0]) | (avs_writedata[14:0] & wmask[14:0]);
            end else if (sel == 3'h3) begin
              if (avs_byteenable[0]) begin
                nxt_buck_main_enable = avs_writedata[`BUCK_MAIN_EN_BIT];
              end
            end
            // status register writes fall through untouched
          end else begin
            if (sel == 3'h0) begin
              nxt_rdata = {29'h0, dis_ff};
            end else if (sel == 3'h1) begin
              nxt_rdata = {23'h0, sts_ff};
            end else if (sel == 3'h2) begin
              nxt_rdata = {17'h0, pc_ff};
            end else if (sel == 3'h3) begin
              nxt_rdata = {31'h0, buck_main_enable_ff};
            end
          end
        end
      end
      BUS_ANSWER: begin
        nxt_state = BUS_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= BUS_IDLE;
      dis_ff <= `DIS_RESET;
      pc_ff <= `PC_RESET;
      buck_main_enable_ff <= `BUCK_RESET;
      rdata_ff <= 32'h00000000;
      resp_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      dis_ff <= nxt_dis;
      pc_ff <= nxt_pc;
      buck_main_enable_ff <= nxt_buck_main_enable;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // waitrequest is low only in the answer cycle
  logic wait_ff;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(state_ff == BUS_IDLE && (avs_read || avs_write));
    end
  end
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;
  assign avs_response = resp_ff;

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  logic [13:0] ctl_ff, nxt_ctl;

  always_comb begin
    nxt_ctl[0] = dis_ff[`DIS_CORE_BIT];
    nxt_ctl[1] = dis_ff[`DIS_BUCK_BIT];
    nxt_ctl[2] = dis_ff[`DIS_IO_BIT];
    nxt_ctl[3] = pc_ff[`PC_CORE_REFBUF];
    nxt_ctl[4] = pc_ff[`PC_IO_REFBUF];
    nxt_ctl[5] = pc_ff[`PC_HOLD_FORCE];
    nxt_ctl[6] = sleep_ff & pc_ff[`PC_BUCK_SLEEP] & buck_main_enable_ff;
    nxt_ctl[7] = sleep_ff ? pc_ff[`PC_CORE_RET_SLP] : pc_ff[`PC_CORE_RET_ACT];
    nxt_ctl[8] = sleep_ff ? pc_ff[`PC_LOW_SLP_EN] : pc_ff[`PC_LOW_ACT_EN];
    nxt_ctl[9] = pc_ff[`PC_LOW_HIGH];
    nxt_ctl[10] = sleep_ff ? pc_ff[`PC_IO_BYP_SLP] : pc_ff[`PC_IO_BYP_ACT];
    nxt_ctl[11] = sleep_ff ? pc_ff[`PC_IO_RET_SLP] : pc_ff[`PC_IO_RET_ACT];
    nxt_ctl[12] = pc_ff[`PC_CORE_REG_EN];
    nxt_ctl[13] = pc_ff[`PC_IO_REG_EN];
  end

  // reset value matches the active-state decode of the register resets
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= 14'h3118;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign {io_reg_en, core_reg_en, io_retention_reg_en, io_reg_bypass, low_reg_high_drive,
          low_reg_en, core_retention_reg_en, buck_on_in_sleep, reference_hold_force,
          io_retention_refbuf_en, core_retention_refbuf_en, io_rail_discharge,
          buck_rail_discharge, core_rail_discharge} = ctl_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_dis_write;
    state_ff == BUS_IDLE && avs_write && sel == 3'h0 && avs_byteenable[0];
  endsequence

  a_core_discharge_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_dis_write |-> ##2 core_rail_discharge == $past(avs_writedata[2], 2))
    else $error("core discharge does not follow write");
  a_io_discharge_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_dis_write |-> ##2 io_rail_discharge == $past(avs_writedata[0], 2))
    else $error("io discharge does not follow write");
  a_buck_discharge_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_dis_write |-> ##2 buck_rail_discharge == $past(avs_writedata[1], 2))
    else $error("buck discharge does not follow write");
  a_flash_flag_path: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(reset_n, 2) |-> sts_ff[`STS_FLASH_SUP_BIT] == $past(flash_supply_above_threshold, 2))
    else $error("flash flag not two-stage copy of comparator");
  a_status_read_data: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == BUS_IDLE && avs_read && sel == 3'h1) |=> avs_readdata == {23'h0, $past(sts_ff)})
    else $error("status read data wrong");
  a_status_write_ignored: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == BUS_IDLE && avs_write && sel == 3'h1) |=> $stable(pc_ff) && $stable(dis_ff))
    else $error("status write changed state");
  a_buck_sleep_and: assert property (@(posedge core_clk) disable iff (!reset_n)
    buck_on_in_sleep |-> $past(sleep_ff && pc_ff[`PC_BUCK_SLEEP] && buck_main_enable_ff))
    else $error("buck sleep enable without both enables");
  a_bypass_select: assert property (@(posedge core_clk) disable iff (!reset_n)
    io_reg_bypass == $past(sleep_ff ? pc_ff[`PC_IO_BYP_SLP] : pc_ff[`PC_IO_BYP_ACT]))
    else $error("bypass not chosen by power state");
  a_wait_one_cycle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not in one cycle");
  a_core_ret_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    core_retention_reg_en == $past(sleep_ff ? pc_ff[`PC_CORE_RET_SLP] : pc_ff[`PC_CORE_RET_ACT]))
    else $error("core retention enable not chosen by power state");
  a_io_ret_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    io_retention_reg_en == $past(sleep_ff ? pc_ff[`PC_IO_RET_SLP] : pc_ff[`PC_IO_RET_ACT]))
    else $error("io retention enable not chosen by power state");
  a_low_reg_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    low_reg_en == $past(sleep_ff ? pc_ff[`PC_LOW_SLP_EN] : pc_ff[`PC_LOW_ACT_EN]))
    else $error("low regulator enable not chosen by power state");
  a_refbuf_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    {core_retention_refbuf_en, io_retention_refbuf_en} == $past(pc_ff[14:13]))
    else $error("reference buffer enables do not follow control");
  a_hold_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    reference_hold_force == $past(pc_ff[`PC_HOLD_FORCE]))
    else $error("reference hold does not follow control");

endmodule // power_rail_control_regs

// ### rtl/power_rail_control_regs.svh
// Purpose: offsets, field positions, reset values of the power rail control bank
// Assumes: 32-bit word-aligned Avalon-MM register window
// Notes:   included by its bare name
`ifndef POWER_RAIL_CONTROL_REGS_SVH
`define POWER_RAIL_CONTROL_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RAIL_DISCHARGE_CONTROL_OFS 32'h500000D4
`define ANALOG_READY_STATUS_OFS 32'h500000DC
`define REGULATOR_ENABLE_CONTROL_OFS 32'h500000E0
`define BUCK_CONVERTER_CONTROL_OFS 32'h500000E8

// ----------------------------------------------------------------
// rail_discharge_control fields
// ----------------------------------------------------------------
`define DIS_IO_BIT 0
`define DIS_BUCK_BIT 1
`define DIS_CORE_BIT 2
`define DIS_RESET 3'h0

// ----------------------------------------------------------------
// analog_ready_status fields
// ----------------------------------------------------------------
`define STS_BANDGAP_BIT 0
`define STS_CORE_REG_BIT 1
`define STS_LOW_REG_BIT 2
`define STS_IO_REG_BIT 3
`define STS_CORE_SUP_BIT 4
`define STS_IO_SUP_BIT 5
`define STS_BUCK_SUP_BIT 6
`define STS_FLASH_SUP_BIT 7
`define STS_ADC_REG_BIT 8
`define STS_WIDTH 9

// ----------------------------------------------------------------
// regulator_enable_control fields
// ----------------------------------------------------------------
`define PC_IO_REG_EN 0
`define PC_LOW_ACT_EN 1
`define PC_CORE_REG_EN 2
`define PC_IO_RET_ACT 3
`define PC_IO_RET_SLP 4
`define PC_IO_BYP_ACT 5
`define PC_IO_BYP_SLP 6
`define PC_LOW_HIGH 7
`define PC_LOW_SLP_EN 8
`define PC_CORE_RET_ACT 9
`define PC_CORE_RET_SLP 10
`define PC_BUCK_SLEEP 11
`define PC_HOLD_FORCE 12
`define PC_IO_REFBUF 13
`define PC_CORE_REFBUF 14
`define PC_WIDTH 15
`define PC_RESET 15'h6517

// ----------------------------------------------------------------
// buck_converter_control fields
// ----------------------------------------------------------------
`define BUCK_MAIN_EN_BIT 0
`define BUCK_RESET 1'h0

`endif

// ### rtl/power_rail_control_pkg.sv
// Purpose: types shared by the power rail control bank
// Assumes: nothing
// Notes:   constants live in the _regs header
package power_rail_control_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

// ### bench/analog_cells_model.sv
// Purpose: behavioural analog cells on the far side of the power rail register bank
// Assumes: one core_clk domain; comparator levels are steered by the bench
// Notes:   regulator ready flags lag their enables by a cycle, as a settling cell would
`timescale 1ns/10ps
module analog_cells_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // levels: adc ready, flash, buck, io, core comparators, bandgap ready
  input wire logic [5:0] comp_level,
  // regulator enables from the bank
  input wire logic io_reg_en,
  input wire logic low_reg_en,
  input wire logic core_reg_en,
  // flags in status bit order 8..0
  output logic [8:0] flags
);
  logic [2:0] ready_ff;

  // a regulator reports ready only after it has been enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_ff <= 3'h0;
    end else begin
      ready_ff <= {io_reg_en, low_reg_en, core_reg_en};
    end
  end

  assign flags = {comp_level[5:1], ready_ff, comp_level[0]};
endmodule // analog_cells_model

// ### bench/testbench.sv
// Purpose: self-checking bench for the power rail register bank
// Assumes: 50 MHz core_clk, Avalon-MM master tasks, analog model as partner
// Notes:   expected register and output values are kept in pc, dis, buck and slp
`timescale 1ns/10ps
`include "power_rail_control_regs.svh"
module testbench;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, pmu_in_sleep;
  logic [31:0] avs_address, avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response;
  logic [5:0] comp_level;
  logic [8:0] flags;
  logic [13:0] outs;
  logic [14:0] pc;
  logic [2:0] dis;
  logic buck, slp;
  int n_fail, n_checks;
  logic [31:0] dv[5] = '{32'h1, 32'h2, 32'h4, 32'hFFFFFFFF, 32'h0};
  logic [31:0] pv[5] = '{32'h0, 32'hFFFF, 32'h2A55, 32'h55AA, 32'h6517};

  power_rail_control_regs DUT (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pmu_in_sleep(pmu_in_sleep),
    .adc_regulator_ready(flags[8]), .flash_supply_above_threshold(flags[7]),
    .buck_supply_above_threshold(flags[6]), .io_supply_above_threshold(flags[5]),
    .core_supply_above_threshold(flags[4]), .io_regulator_ready(flags[3]),
    .low_regulator_ready(flags[2]), .core_regulator_ready(flags[1]),
    .bandgap_ready(flags[0]), .core_rail_discharge(outs[13]),
    .buck_rail_discharge(outs[12]), .io_rail_discharge(outs[11]),
    .core_retention_refbuf_en(outs[10]), .io_retention_refbuf_en(outs[9]),
    .reference_hold_force(outs[8]), .buck_on_in_sleep(outs[7]),
    .core_retention_reg_en(outs[6]), .low_reg_en(outs[5]), .low_reg_high_drive(outs[4]),
    .io_reg_bypass(outs[3]), .io_retention_reg_en(outs[2]), .core_reg_en(outs[1]),
    .io_reg_en(outs[0]));

  analog_cells_model partner (.core_clk(core_clk), .reset_n(reset_n),
    .comp_level(comp_level), .io_reg_en(outs[0]), .low_reg_en(outs[5]),
    .core_reg_en(outs[1]), .flags(flags));

  always #10 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // waitrequest is sampled on the edge, before the bank's own updates land
  task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] r, output logic [1:0] s);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    r = avs_readdata;
    s = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] r;
    logic [1:0] s;
    access(1'h0, a, 32'h0, 4'hF, r, s);
    check(r, exp);
    check({30'h0, s}, {30'h0, rexp});
  endtask

  task automatic put(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    logic [1:0] s;
    access(1'h1, a, d, be, r, s);
    if (a == `REGULATOR_ENABLE_CONTROL_OFS && be[0]) pc[7:0] = d[7:0];
    if (a == `REGULATOR_ENABLE_CONTROL_OFS && be[1]) pc[14:8] = d[14:8];
    if (a == `RAIL_DISCHARGE_CONTROL_OFS && be[0]) dis = d[2:0];
    if (a == `BUCK_CONVERTER_CONTROL_OFS && be[0]) buck = d[0];
  endtask

  function automatic logic [13:0] exp_outs();
    return {dis, pc[14:12], slp & pc[11] & buck, slp ? pc[10] : pc[9], slp ? pc[8] : pc[1],
            pc[7], slp ? pc[6] : pc[5], slp ? pc[4] : pc[3], pc[2], pc[0]};
  endfunction

  // six edges cover sync flops plus the model's settling cycle
  task automatic verify();
    logic [8:0] st;
    tick(6);
    st = {comp_level[5:1], pc[0], slp ? pc[8] : pc[1], pc[2], comp_level[0]};
    check({18'h0, outs}, {18'h0, exp_outs()});
    rd(`RAIL_DISCHARGE_CONTROL_OFS, {29'h0, dis}, 2'h0);
    rd(`REGULATOR_ENABLE_CONTROL_OFS, {17'h0, pc}, 2'h0);
    rd(`ANALOG_READY_STATUS_OFS, {23'h0, st}, 2'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end

  initial begin
    core_clk = 1'h0;
    reset_n = 1'h0;
    {avs_read, avs_write, pmu_in_sleep, buck, slp} = 5'h0;
    {avs_address, avs_writedata, avs_byteenable, comp_level, dis} = 77'h0;
    pc = 15'h6517;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    verify();
    $display("test reset_values done");
    foreach (dv[i]) begin
      put(`RAIL_DISCHARGE_CONTROL_OFS, dv[i], 4'hF);
      verify();
    end
    $display("test discharge done");
    for (int b = 0; b < 2; b++) begin
      put(`BUCK_CONVERTER_CONTROL_OFS, 32'(b), 4'h1);
      for (int s = 0; s < 2; s++) begin
        pmu_in_sleep <= s[0];
        slp = s[0];
        foreach (pv[i]) begin
          put(`REGULATOR_ENABLE_CONTROL_OFS, pv[i], 4'hF);
          verify();
        end
      end
    end
    pmu_in_sleep <= 1'h0;
    slp = 1'h0;
    put(`REGULATOR_ENABLE_CONTROL_OFS, 32'hFFFFFFFF, 4'h1);
    put(`REGULATOR_ENABLE_CONTROL_OFS, 32'h0, 4'h2);
    verify();
    $display("test power_control done");
    for (int i = 0; i < 7; i++) begin
      comp_level <= (i == 6) ? 6'h3F : 6'(1 << i);
      verify();
    end
    // flash flag is unfiltered, so it is read repeatedly before being trusted
    repeat (3) rd(`ANALOG_READY_STATUS_OFS, {23'h0, 9'h1FF}, 2'h0);
    put(`ANALOG_READY_STATUS_OFS, 32'h0, 4'hF);
    verify();
    rd(32'h500000D8, 32'h0, 2'h2);
    put(32'h500000E4, 32'hFFFFFFFF, 4'hF);
    verify();
    $display("test status_and_unmapped done");
    put(`RAIL_DISCHARGE_CONTROL_OFS, 32'h7, 4'hF);
    put(`REGULATOR_ENABLE_CONTROL_OFS, 32'h0, 4'hF);
    reset_n <= 1'h0;
    {pc, dis, buck} = {15'h6517, 3'h0, 1'h0};
    tick(3);
    check({18'h0, outs}, {18'h0, exp_outs()});
    reset_n <= 1'h1;
    verify();
    $display("test mid_run_reset done");
    end_of_test();
  end
endmodule // testbench
